// ### common/adc_seq_pkg.sv
package adc_seq_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_PRECHARGE_TIME = 8'h00;
    localparam logic [7:0] OFF_ACQUISITION_TIME = 8'h04;
    localparam logic [7:0] OFF_GUARD_RING_CONTROL = 8'h08;
    localparam logic [7:0] OFF_EXTRA_SAMPLE_CAP_SELECT = 8'h0C;
    localparam logic [7:0] OFF_CONV_CONTROL = 8'h10;
    localparam logic [7:0] OFF_CONV_STATUS = 8'h14;

    // Reset values
    localparam logic [7:0] RST_PRECHARGE_TIME = 8'h00;
    localparam logic [7:0] RST_ACQUISITION_TIME = 8'h00;
    localparam logic [2:0] RST_GUARD = 3'h0;
    localparam logic [2:0] RST_CAP = 3'h0;

    // Field layout
    localparam int TIME_W = 7;
    localparam int CAP_W = 3;
    localparam int GRD_B_OE_BIT = 7;
    localparam int GRD_A_OE_BIT = 6;
    localparam int GRD_POL_BIT = 5;
    localparam int CTL_ON_BIT = 0;
    localparam int CTL_GO_BIT = 1;
    localparam int CTL_DSEN_BIT = 2;
    localparam int CTL_IPEN_BIT = 3;
    localparam int CTL_OSC_BIT = 4;
    localparam int STS_SECOND_BIT = 2;

    // Instruction cycle is the system clock divided by four
    localparam int ICYC_DIV = 4;
    localparam logic [1:0] ICYC_LAST = 2'(ICYC_DIV - 1);
    // Conversion stage length in timing ticks
    localparam logic [3:0] CONV_TICKS = 4'hB;

    typedef enum logic [1:0] {
        STG_IDLE = 2'b00,
        STG_PRE = 2'b01,
        STG_ACQ = 2'b10,
        STG_CONV = 2'b11
    } stage_t;

endpackage

// ### core/tick_gen.sv
`timescale 1ns/10ps
// Timing tick: instruction cycle or dedicated oscillator edge
module tick_gen
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic use_osc,
    input wire logic osc_clk_in,
    output logic tick
);
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    wire div_wrap = (div_q == ICYC_LAST);
    wire osc_rise = osc_s2_q & ~osc_s3_q;

    assign div_d = div_wrap ? 2'h0 : div_q + 2'h1;
    assign tick = use_osc ? osc_rise : div_wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            div_q <= div_d;
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
endmodule // tick_gen

// ### core/adc_precharge_acq_sequencer.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Behaviour
// - Stage status 11 conv, 10 acq, 01 pre
// - Stage status 00 when idle
// - Nonzero pre-charge field gives N cycles
// - Zero pre-charge field skips pre-charge
// - Count unit is one instruction cycle
// - Nonzero acquisition field gives N cycles
// - Zero acquisition field skips acquisition
// - Dedicated oscillator also times both stages
// - Unimplemented register bits read zero
// - Guard B enable routes guard to pin
// - Guard A enable routes guard to pin
// - Polarity bit sets guard starting level
// - Guard outputs held while converter on
// - Guard A toggles at acquisition start
// - Second conversion inverts, stored bit kept
// - Capacitor select adds 4 pF steps
// - Double sample restarts, start flag kept
module adc_precharge_acq_sequencer
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_clk_in,
    output logic guard_pin_a,
    output logic guard_pin_a_oe_n,
    output logic guard_pin_b,
    output logic guard_pin_b_oe_n,
    output logic [CAP_W-1:0] extra_cap_sel,
    output logic [1:0] stage_status,
    output logic conv_done_pulse
);
    logic [TIME_W-1:0] precharge_count_q;
    logic [TIME_W-1:0] acquisition_count_q;
    logic guard_b_out_en_q;
    logic guard_a_out_en_q;
    logic guard_start_level_q;
    logic [CAP_W-1:0] extra_cap_sel_q;
    logic converter_on_q;
    logic go_q;
    logic double_sample_en_q;
    logic second_invert_en_q;
    logic dedicated_conv_osc_q;
    logic second_q;
    stage_t stg_q;
    stage_t stg_d;
    logic [TIME_W-1:0] tmr_q;
    logic [TIME_W-1:0] tmr_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;
    logic grd_a_q;
    logic grd_b_q;
    logic grd_a_oe_n_q;
    logic grd_b_oe_n_q;
    logic done_q;
    logic tick;

    tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .use_osc(dedicated_conv_osc_q),
        .osc_clk_in(osc_clk_in),
        .tick(tick)
    );

    // APB decode; no wait state, pready registered from setup so every output stays registered
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    wire wr = access & pwrite;
    wire hit_pre = (paddr == OFF_PRECHARGE_TIME);
    wire hit_acq = (paddr == OFF_ACQUISITION_TIME);
    wire hit_grd = (paddr == OFF_GUARD_RING_CONTROL);
    wire hit_cap = (paddr == OFF_EXTRA_SAMPLE_CAP_SELECT);
    wire hit_ctl = (paddr == OFF_CONV_CONTROL);
    wire hit_sts = (paddr == OFF_CONV_STATUS);
    wire hit_any = hit_pre | hit_acq | hit_grd | hit_cap | hit_ctl | hit_sts;

    wire [31:0] rd_pre = {25'h0, precharge_count_q};
    wire [31:0] rd_acq = {25'h0, acquisition_count_q};
    wire [31:0] rd_grd = {24'h0, guard_b_out_en_q, guard_a_out_en_q,
                          guard_start_level_q, 5'h00};
    wire [31:0] rd_cap = {29'h0, extra_cap_sel_q};
    wire [31:0] rd_ctl = {27'h0, dedicated_conv_osc_q, second_invert_en_q,
                          double_sample_en_q, go_q, converter_on_q};
    wire [31:0] rd_sts = {29'h0, second_q, stg_q};
    wire [31:0] rd_mux = hit_pre ? rd_pre :
                         hit_acq ? rd_acq :
                         hit_grd ? rd_grd :
                         hit_cap ? rd_cap :
                         hit_ctl ? rd_ctl :
                         hit_sts ? rd_sts : 32'h0000_0000;

    // Per-register write strobes
    wire wr_pre = wr & hit_pre;
    wire wr_acq = wr & hit_acq;
    wire wr_grd = wr & hit_grd;
    wire wr_cap = wr & hit_cap;
    wire wr_ctl = wr & hit_ctl;

    // Sequencer next state
    wire tmr_end = tick & (tmr_q == 7'h01);
    wire conv_end = (stg_q == STG_CONV) & tmr_end;
    wire go_set = wr_ctl & pwdata[CTL_GO_BIT] & pwdata[CTL_ON_BIT];
    wire start = (stg_q == STG_IDLE) & go_q & converter_on_q;
    // Double sample chains into the next conversion with no idle gap
    wire restart = conv_end & go_q & double_sample_en_q;
    wire pre_skip = (precharge_count_q == 7'h00);
    wire acq_skip = (acquisition_count_q == 7'h00);
    stage_t first_stg;
    logic [TIME_W-1:0] first_tmr;
    assign first_stg = !pre_skip ? STG_PRE : (!acq_skip ? STG_ACQ : STG_CONV);
    assign first_tmr = !pre_skip ? precharge_count_q :
                       (!acq_skip ? acquisition_count_q : {3'h0, CONV_TICKS});

    always_comb begin
        stg_d = stg_q;
        tmr_d = tmr_q;
        if (tick && tmr_q != 7'h00) begin
            tmr_d = tmr_q - 7'h01;
        end
        case (stg_q)
            STG_IDLE: begin
                if (start) begin
                    if (!pre_skip) begin
                        stg_d = STG_PRE;
                        tmr_d = precharge_count_q;
                    end else if (!acq_skip) begin
                        stg_d = STG_ACQ;
                        tmr_d = acquisition_count_q;
                    end else begin
                        stg_d = STG_CONV;
                        tmr_d = {3'h0, CONV_TICKS};
                    end
                end
            end
            STG_PRE: begin
                if (tmr_end) begin
                    if (!acq_skip) begin
                        stg_d = STG_ACQ;
                        tmr_d = acquisition_count_q;
                    end else begin
                        stg_d = STG_CONV;
                        tmr_d = {3'h0, CONV_TICKS};
                    end
                end
            end
            STG_ACQ: begin
                if (tmr_end) begin
                    stg_d = STG_CONV;
                    tmr_d = {3'h0, CONV_TICKS};
                end
            end
            STG_CONV: begin
                if (restart) begin
                    stg_d = first_stg;
                    tmr_d = first_tmr;
                end else if (tmr_end) begin
                    stg_d = STG_IDLE;
                end
            end
            default: begin
                stg_d = STG_IDLE;
            end
        endcase
        if (!converter_on_q) begin
            stg_d = STG_IDLE;
        end
    end

    // Next pair position; a chained conversion must see its own polarity
    wire second_d = go_q & double_sample_en_q & (second_q ^ conv_end);
    wire inv = second_d & double_sample_en_q & second_invert_en_q;
    wire start_lvl = guard_start_level_q ^ inv;
    wire entering_pre = (stg_q != STG_PRE) & (stg_d == STG_PRE);
    wire entering_acq = (stg_q != STG_ACQ) & (stg_d == STG_ACQ);
    wire idle_track = (stg_q == STG_IDLE) & ~start;
    wire conv_rerun = restart & (first_stg == STG_CONV);
    wire load_lvl = entering_pre | idle_track | conv_rerun;
    // Guard A level just before its flip into acquisition
    wire acq_base = (stg_q == STG_PRE) ? grd_a_q : start_lvl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    // Read data captured at setup, held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup & ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            precharge_count_q <= RST_PRECHARGE_TIME[TIME_W-1:0];
        end else if (wr_pre) begin
            precharge_count_q <= pwdata[TIME_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acquisition_count_q <= RST_ACQUISITION_TIME[TIME_W-1:0];
        end else if (wr_acq) begin
            acquisition_count_q <= pwdata[TIME_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {guard_b_out_en_q, guard_a_out_en_q, guard_start_level_q} <= RST_GUARD;
        end else if (wr_grd) begin
            guard_b_out_en_q <= pwdata[GRD_B_OE_BIT];
            guard_a_out_en_q <= pwdata[GRD_A_OE_BIT];
            guard_start_level_q <= pwdata[GRD_POL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extra_cap_sel_q <= RST_CAP;
        end else if (wr_cap) begin
            extra_cap_sel_q <= pwdata[CAP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {converter_on_q, double_sample_en_q, second_invert_en_q} <= 3'h0;
            dedicated_conv_osc_q <= 1'b0;
        end else if (wr_ctl) begin
            converter_on_q <= pwdata[CTL_ON_BIT];
            double_sample_en_q <= pwdata[CTL_DSEN_BIT];
            second_invert_en_q <= pwdata[CTL_IPEN_BIT];
            dedicated_conv_osc_q <= pwdata[CTL_OSC_BIT];
        end
    end

    // Start flag: hardware clear at end of a single conversion; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= 1'b0;
        end else if (go_set) begin
            go_q <= 1'b1;
        end else if (wr && hit_ctl) begin
            go_q <= 1'b0;
        end else if (!converter_on_q || (conv_end && !double_sample_en_q)) begin
            go_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_q <= STG_IDLE;
            tmr_q <= 7'h00;
        end else begin
            stg_q <= stg_d;
            tmr_q <= tmr_d;
        end
    end

    // End-of-conversion strobe rises on the same edge as the stage change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= conv_end;
        end
    end

    // Alternates which conversion of a pair is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_q <= 1'b0;
        end else begin
            second_q <= second_d;
        end
    end

    // Guard pins float back while the converter is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grd_a_oe_n_q <= 1'b1;
            grd_b_oe_n_q <= 1'b1;
        end else begin
            grd_a_oe_n_q <= ~(converter_on_q & guard_a_out_en_q);
            grd_b_oe_n_q <= ~(converter_on_q & guard_b_out_en_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grd_a_q <= 1'b0;
        end else if (load_lvl) begin
            grd_a_q <= start_lvl;
        end else if (entering_acq) begin
            grd_a_q <= ~acq_base;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grd_b_q <= 1'b0;
        end else if (load_lvl) begin
            grd_b_q <= start_lvl;
        end else if (entering_acq) begin
            grd_b_q <= acq_base;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign guard_pin_a = grd_a_q;
    assign guard_pin_b = grd_b_q;
    assign guard_pin_a_oe_n = grd_a_oe_n_q;
    assign guard_pin_b_oe_n = grd_b_oe_n_q;
    assign extra_cap_sel = extra_cap_sel_q;
    assign stage_status = stg_q;
    assign conv_done_pulse = done_q;
endmodule // adc_precharge_acq_sequencer

// ### sim/adc_front_model.sv
`timescale 1ns/10ps
module adc_front_model (
    input wire logic pin_a,
    input wire logic pin_a_oe_n,
    input wire logic pin_b,
    input wire logic pin_b_oe_n,
    output logic osc_clk,
    output logic lvl_a,
    output logic lvl_b
);
    // Oscillator runs free, phase unrelated to pclk
    initial begin
        osc_clk = 1'b0;
        forever #65 osc_clk = ~osc_clk;
    end
    // Pull-down holds a released guard pin low
    assign lvl_a = pin_a_oe_n ? 1'b0 : pin_a;
    assign lvl_b = pin_b_oe_n ? 1'b0 : pin_b;
endmodule // adc_front_model

// ### sim/adc_seq_checker.sv
`timescale 1ns/10ps
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_clk_in,
    input wire logic conv_done_pulse,
    input wire logic guard_pin_a,
    input wire logic guard_pin_a_oe_n,
    input wire logic guard_pin_b,
    input wire logic guard_pin_b_oe_n,
    input wire logic [CAP_W-1:0] extra_cap_sel,
    input wire logic [1:0] stage_status
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_READY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready timing");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_CAP_COPY: assert property (pready && pwrite && !pslverr &&
        paddr == OFF_EXTRA_SAMPLE_CAP_SELECT |=> extra_cap_sel == $past(pwdata[2:0]))
        else $error("cap select not copied");
    AST_ACQ_NEXT: assert property ($past(stage_status) == 2'b10 && stage_status != 2'b10
        |-> stage_status inside {2'b11, 2'b00})
        else $error("bad stage after acquisition");
    AST_DONE_AFTER_CONV: assert property (conv_done_pulse
        |-> $past(stage_status) == 2'b11 || $past(stage_status, 2) == 2'b11)
        else $error("done pulse outside conversion end");
    AST_CONV_END_DONE: assert property ($past(stage_status) == 2'b11
        && stage_status == 2'b00
        && !$past(psel && penable && pready && pwrite && paddr == OFF_CONV_CONTROL, 2)
        |-> ##[0:2] conv_done_pulse)
        else $error("no done pulse");
    AST_GRD_PRE_EQ: assert property ((stage_status == 2'b01)[*3]
        ##0 !guard_pin_a_oe_n && !guard_pin_b_oe_n |-> guard_pin_a == guard_pin_b)
        else $error("guards differ in pre-charge");
    AST_GRD_ACQ_TGL: assert property ((stage_status == 2'b10)[*3]
        ##0 !guard_pin_a_oe_n && !guard_pin_b_oe_n |-> guard_pin_a != guard_pin_b)
        else $error("guard a not toggled");
endmodule // adc_seq_checker
bind adc_precharge_acq_sequencer adc_seq_checker i_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_clk_in(osc_clk_in),
    .conv_done_pulse(conv_done_pulse),
    .guard_pin_a(guard_pin_a),
    .guard_pin_a_oe_n(guard_pin_a_oe_n),
    .guard_pin_b(guard_pin_b),
    .guard_pin_b_oe_n(guard_pin_b_oe_n),
    .extra_cap_sel(extra_cap_sel),
    .stage_status(stage_status)
);

// ### sim/tb_adc_precharge_acq_sequencer.sv
`timescale 1ns/10ps
module tb_adc_precharge_acq_sequencer
    import adc_seq_pkg::*;
;
    typedef struct {logic [1:0] stg; int ns; int tol; logic ck; logic [1:0] grd;} note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_clk_in;
    logic guard_pin_a, guard_pin_a_oe_n, guard_pin_b, guard_pin_b_oe_n;
    logic conv_done_pulse, lvl_a, lvl_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [CAP_W-1:0] extra_cap_sel;
    logic [1:0] stage_status, prv_stg, lst_g;
    logic [32:0] rdq[$];
    note_t stq[$];
    note_t cur;
    int err_count, n_checks, seed, k, d;
    time t0;
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    adc_precharge_acq_sequencer i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_clk_in(osc_clk_in),
        .guard_pin_a(guard_pin_a),
        .guard_pin_a_oe_n(guard_pin_a_oe_n),
        .guard_pin_b(guard_pin_b),
        .guard_pin_b_oe_n(guard_pin_b_oe_n),
        .extra_cap_sel(extra_cap_sel),
        .stage_status(stage_status),
        .conv_done_pulse(conv_done_pulse)
    );
    adc_front_model i_front (.pin_a(guard_pin_a), .pin_a_oe_n(guard_pin_a_oe_n),
        .pin_b(guard_pin_b), .pin_b_oe_n(guard_pin_b_oe_n), .osc_clk(osc_clk_in),
        .lvl_a(lvl_a), .lvl_b(lvl_b));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_count++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Sequence with both guards enabled; start level po, tick period set by osc select
    task automatic run(input logic [6:0] pr, input logic [6:0] aq, input logic [4:0] c,
        input logic po);
        int p;
        int tl;
        int w;
        p = c[4] ? 130 : 80;
        tl = c[4] ? 120 : 60;
        apb(1'b1, OFF_PRECHARGE_TIME, {25'h0, pr});
        apb(1'b1, OFF_ACQUISITION_TIME, {25'h0, aq});
        apb(1'b1, OFF_GUARD_RING_CONTROL, {24'h0, 2'b11, po, 5'h00});
        for (int i = 0; i < (c[2] ? 2 : 1); i++) begin
            if (pr != 0) stq.push_back('{2'b01, pr * p, tl, 1'b1, {po, po}});
            if (aq != 0) stq.push_back('{2'b10, aq * p, tl, 1'b1, {~po, po}});
            stq.push_back('{2'b11, 11 * p, tl, 1'b0, 2'b00});
            po = po ^ c[3];
        end
        stq.push_back('{c[2] ? 2'b01 : 2'b00, 0, 0, 1'b0, 2'b00});
        apb(1'b1, OFF_CONV_CONTROL, {27'h0, c});
        w = 0;
        for (int n = 0; n < (c[2] ? 2 : 1) && w < 9000; w++) begin
            @(posedge pclk);
            if (conv_done_pulse === 1'b1) n++;
        end
        if (w >= 9000) begin
            err_count++;
            stop_test();
        end
        if (c[2]) begin
            stq.push_back('{2'b00, 0, 0, 1'b0, 2'b00});
            apb(1'b1, OFF_CONV_CONTROL, 32'h0000_0000);
            rd(OFF_GUARD_RING_CONTROL, {25'h0, 2'b11, po, 5'h00});
            repeat (2) @(negedge pclk);
            chk(guard_pin_a_oe_n, 1'b1);
        end
        rd(OFF_CONV_STATUS, 33'h0_0000_0000);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, rdq.pop_front());
    end
    always @(negedge pclk) begin
        if (stage_status !== prv_stg) begin
            d = int'($time - t0);
            if (cur.ns > 0) chk((d <= cur.ns + 60 && d + cur.tol >= cur.ns) ? cur.ns : d, cur.ns);
            if (cur.ck === 1'b1) chk(lst_g, cur.grd);
            if (stq.size() == 0) begin
                chk(stage_status, 33'h1_0000_0000);
            end else begin
                cur = stq.pop_front();
                chk(stage_status, cur.stg);
            end
            t0 = $time;
        end
        lst_g = {lvl_a, lvl_b};
        prv_stg = stage_status;
    end
    initial begin
        seed = 88;
        prv_stg = 2'b00;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 4; a++) rd(8'(4 * a), 33'h0_0000_0000);
        for (int a = 0; a < 4; a++) apb(1'b1, 8'(4 * a), 32'hFFFF_FFFF);
        rd(OFF_PRECHARGE_TIME, 33'h0_0000_007F);
        rd(OFF_ACQUISITION_TIME, 33'h0_0000_007F);
        rd(OFF_GUARD_RING_CONTROL, 33'h0_0000_00E0);
        rd(OFF_EXTRA_SAMPLE_CAP_SELECT, 33'h0_0000_0007);
        rd(8'h18, 33'h1_0000_0000);
        repeat (6) begin
            rv = $random(seed);
            apb(1'b1, OFF_EXTRA_SAMPLE_CAP_SELECT, rv);
            repeat (2) @(negedge pclk);
            chk(extra_cap_sel, rv[2:0]);
        end
        run(7'd3, 7'd2, 5'h03, 1'b0);
        run(7'd0, 7'd2, 5'h03, 1'b1);
        run(7'd2, 7'd0, 5'h03, 1'b0);
        run(7'd0, 7'd0, 5'h03, 1'b1);
        run(7'd2, 7'd3, 5'h13, 1'b1);
        run(7'd127, 7'd127, 5'h03, 1'b0);
        rv = $random(seed);
        run({4'h0, rv[2:0]}, {4'h0, rv[5:3]}, 5'h03, rv[6]);
        run(7'd3, 7'd2, 5'h0F, 1'b0);
        stop_test();
    end
endmodule // tb_adc_precharge_acq_sequencer
